// File: sal_aux_irq_map.svh
`ifndef SAL_AUX_IRQ_MAP_SVH
`define SAL_AUX_IRQ_MAP_SVH

// Register offsets (byte addresses)
`define SAL_OFS_REQ_LEN    12'h03C
`define SAL_OFS_CAUSE      12'h040
`define SAL_OFS_MASK       12'h060
`define SAL_OFS_CAUSE_CLR  12'h064

// Cause bit positions
`define SAL_BIT_TP3        18
`define SAL_BIT_TP2        17
`define SAL_BIT_TP1        16
`define SAL_BIT_TRAIN_DONE 14
`define SAL_BIT_DOWN_REQ   12
`define SAL_BIT_VC_DEALLOC 11
`define SAL_BIT_VC_ALLOC   10
`define SAL_BIT_EXT_PKT    9
`define SAL_BIT_VIDEO      6
`define SAL_BIT_TRAIN_LOST 4
`define SAL_BIT_VBLANK     3
`define SAL_BIT_NO_VIDEO   2
`define SAL_BIT_MODE_CHG   1

// Bits that exist in the cause register; all others read zero
`define SAL_CAUSE_IMPL     32'h0007_5E5E
`define SAL_CAUSE_RST      32'h0000_0000
`define SAL_MASK_RST       32'hFFFF_FFFF

// Flags inside the blanking id byte
`define SAL_BID_VBLANK     0
`define SAL_BID_NO_VIDEO   3

// Longest accepted request payload and the count subtracted for the length register, in bytes
`define SAL_LEN_MAX        5'h10
`define SAL_LEN_MIN        5'h01

`endif

// File: sal_pkg.sv
`default_nettype none
package sal_pkg;

    localparam int ADDR_W = 12;
    localparam int ATTR_W = 48;

    typedef enum logic [1:0]
    {
        TRN_IDLE    = 2'h1,
        TRN_TRAINED = 2'h2
    } sal_train_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wrData;
        logic              wrStb;
        logic              rdStb;
    } sal_bus_req_t;

    typedef struct packed
    {
        logic              tp1Start;
        logic              tp2Start;
        logic              tp3Start;
        logic              trainDone;
        logic              linkLocked;
        logic              downReqAvail;
        logic              vcDealloc;
        logic              vcAlloc;
        logic              extension_packet_arrived;
        logic              videoFrame;
        logic              bidValid;
        logic [7:0]        blanking_id_byte;
        logic              attrValid;
        logic [ATTR_W-1:0] stream_attributes;
        logic              auxReqValid;
        logic              auxAddrOnly;
        logic [4:0]        auxReqBytes;
    } sal_link_ev_t;

    typedef struct packed
    {
        logic [31:0]       cause;
        logic [31:0]       mask;
        logic [3:0]        reqLen;
        sal_train_t        train;
        logic              vblPrev;
        logic              videoSeen;
        logic [ATTR_W-1:0] attr;
        logic              attrKnown;
        logic [31:0]       rdData;
    } sal_state_t;

endpackage
`default_nettype wire

// File: sal_aux_irq.sv
// Behaviour
// - Request length register holds byte count minus one in four bits.
// - Requests carrying one to sixteen data bytes are captured.
// - Address-only requests report a length of zero.
// - Reading the cause register returns pending bits, then clears all.
// - Writing the cause register is illegal and clears all bits.
// - Training pattern 1, 2, 3 starts set bits 16, 17, 18.
// - Finished link training sets the training-complete bit.
// - Available downstream request message sets bit 12.
// - Payload deallocation event sets bit 11.
// - Payload allocation event sets bit 10.
// - Arrived extension packet sets bit 9.
// - Valid video frame sets bit 6; bit 5 reserved.
// - Losing lock after training sets bit 4.
// - Start of vertical blanking sets bit 3.
// - No-video flag after active video sets bit 2.
// - Changed stream attributes set bit 1.
// - Per-source mask bits, one blocks, all set after reset.
//
// The implementer's own choice: the strobed register port.
`include "sal_aux_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sal_aux_irq
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire sal_pkg::sal_bus_req_t bus,
    input  wire sal_pkg::sal_link_ev_t link,
    output logic [31:0]              rdData,
    output logic                     irq
);

    sal_pkg::sal_state_t s_reg;
    sal_pkg::sal_state_t s_next;
    logic [31:0]         evSet;
    logic [31:0]         causeBase;
    logic                causeHit;
    logic                lenOk;
    logic                vblFlag;
    logic                noVidFlag;

    localparam sal_pkg::sal_state_t S_RST = '{
        cause:     `SAL_CAUSE_RST,
        mask:      `SAL_MASK_RST,
        reqLen:    4'h0,
        train:     sal_pkg::TRN_IDLE,
        vblPrev:   1'b0,
        videoSeen: 1'b0,
        attr:      '0,
        attrKnown: 1'b0,
        rdData:    32'h0000_0000
    };

    always_comb
    begin
        s_next    = s_reg;
        evSet     = 32'h0000_0000;
        vblFlag   = link.blanking_id_byte[`SAL_BID_VBLANK];
        noVidFlag = link.blanking_id_byte[`SAL_BID_NO_VIDEO];
        lenOk     = (link.auxReqBytes <= `SAL_LEN_MAX);

        // Plain link events
        evSet[`SAL_BIT_TP1]        = link.tp1Start;
        evSet[`SAL_BIT_TP2]        = link.tp2Start;
        evSet[`SAL_BIT_TP3]        = link.tp3Start;
        evSet[`SAL_BIT_TRAIN_DONE] = link.trainDone;
        evSet[`SAL_BIT_DOWN_REQ]   = link.downReqAvail;
        evSet[`SAL_BIT_VC_DEALLOC] = link.vcDealloc;
        evSet[`SAL_BIT_VC_ALLOC]   = link.vcAlloc;
        evSet[`SAL_BIT_EXT_PKT]    = link.extension_packet_arrived;
        evSet[`SAL_BIT_VIDEO]      = link.videoFrame;

        // Loss is only meaningful once training has completed
        case (s_reg.train)
            sal_pkg::TRN_IDLE:
            begin
                if (link.trainDone)
                begin
                    s_next.train = sal_pkg::TRN_TRAINED;
                end
            end
            sal_pkg::TRN_TRAINED:
            begin
                if (!link.linkLocked)
                begin
                    evSet[`SAL_BIT_TRAIN_LOST] = 1'b1;
                    s_next.train = sal_pkg::TRN_IDLE;
                end
                else if (link.tp1Start)
                begin
                    // Retraining is not a loss
                    s_next.train = sal_pkg::TRN_IDLE;
                end
            end
            default:
            begin
                s_next.train = sal_pkg::TRN_IDLE;
            end
        endcase

        // A completion in the same cycle as a loss or a retrain start still leaves the link trained
        if (link.trainDone)
        begin
            s_next.train = sal_pkg::TRN_TRAINED;
        end

        // Blanking id byte: edge on the vertical flag, no-video after video
        if (link.bidValid)
        begin
            s_next.vblPrev = vblFlag;
            if (vblFlag && !s_reg.vblPrev)
            begin
                evSet[`SAL_BIT_VBLANK] = 1'b1;
            end
            if (noVidFlag)
            begin
                if (s_reg.videoSeen)
                begin
                    evSet[`SAL_BIT_NO_VIDEO] = 1'b1;
                end
                s_next.videoSeen = 1'b0;
            end
            else
            begin
                s_next.videoSeen = 1'b1;
            end
        end
        else if (link.videoFrame)
        begin
            s_next.videoSeen = 1'b1;
        end

        // First attribute set after reset only primes the comparison
        if (link.attrValid)
        begin
            if (s_reg.attrKnown && (link.stream_attributes != s_reg.attr))
            begin
                evSet[`SAL_BIT_MODE_CHG] = 1'b1;
            end
            s_next.attr      = link.stream_attributes;
            s_next.attrKnown = 1'b1;
        end

        // Oversized requests are not captured and leave the old length
        if (link.auxReqValid && lenOk)
        begin
            if (link.auxAddrOnly || (link.auxReqBytes == 5'h00))
            begin
                s_next.reqLen = 4'h0;
            end
            else
            begin
                s_next.reqLen = 4'(link.auxReqBytes - `SAL_LEN_MIN);
            end
        end

        // Any access to the cause register wipes it; new events still land
        causeHit  = (bus.rdStb || bus.wrStb) && (bus.addr == `SAL_OFS_CAUSE);
        causeBase = causeHit ? 32'h0000_0000 : s_reg.cause;
        if (bus.wrStb && (bus.addr == `SAL_OFS_CAUSE_CLR))
        begin
            causeBase = causeBase & ~bus.wrData;
        end
        s_next.cause = (causeBase | evSet) & `SAL_CAUSE_IMPL;

        if (bus.wrStb && (bus.addr == `SAL_OFS_MASK))
        begin
            s_next.mask = bus.wrData;
        end

        s_next.rdData = 32'h0000_0000;
        if (bus.rdStb)
        begin
            case (bus.addr)
                `SAL_OFS_REQ_LEN: s_next.rdData = {28'h000_0000, s_reg.reqLen};
                `SAL_OFS_CAUSE:   s_next.rdData = s_reg.cause;
                `SAL_OFS_MASK:    s_next.rdData = s_reg.mask;
                default:          s_next.rdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_reg <= S_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rdData = s_reg.rdData;
    assign irq    = |(s_reg.cause & ~s_reg.mask);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_LEN_MINUS1: assert property (
        link.auxReqValid && !link.auxAddrOnly && (link.auxReqBytes != 5'h00)
        && (link.auxReqBytes <= 5'h10)
        |=> s_reg.reqLen == 4'($past(link.auxReqBytes) - 5'h01))
        else $error("Request length not byte count minus one");

    AST_LEN_OVERSIZE: assert property (
        link.auxReqValid && (link.auxReqBytes > 5'h10) |=> $stable(s_reg.reqLen))
        else $error("Oversized request changed the length");

    AST_LEN_ADDR_ONLY: assert property (
        link.auxReqValid && link.auxAddrOnly |=> s_reg.reqLen == 4'h0)
        else $error("Address-only request length not zero");

    AST_RD_CLEARS: assert property (
        bus.rdStb && (bus.addr == 12'h040) && (evSet == 32'h0000_0000)
        |=> (s_reg.cause == 32'h0000_0000) && (rdData == $past(s_reg.cause)))
        else $error("Cause read did not return and clear");

    AST_WR_CLEARS: assert property (
        bus.wrStb && (bus.addr == 12'h040) && (evSet == 32'h0000_0000)
        |=> s_reg.cause == 32'h0000_0000)
        else $error("Cause write did not clear");

    AST_TP_BITS: assert property (
        link.tp1Start || link.tp2Start || link.tp3Start
        |=> ((s_reg.cause[18:16] & $past({link.tp3Start, link.tp2Start, link.tp1Start}))
            == $past({link.tp3Start, link.tp2Start, link.tp1Start})))
        else $error("Training pattern start bit not set");

    AST_TRAIN_DONE: assert property (
        link.trainDone |=> s_reg.cause[14] && (s_reg.train == sal_pkg::TRN_TRAINED))
        else $error("Training complete not recorded");

    AST_DOWN_REQ: assert property (
        link.downReqAvail |=> s_reg.cause[12])
        else $error("Down request bit not set");

    AST_VC_EVENTS: assert property (
        link.vcDealloc && link.vcAlloc |=> s_reg.cause[11] && s_reg.cause[10])
        else $error("Payload event bits not set");

    AST_EXT_PKT: assert property (
        link.extension_packet_arrived |=> s_reg.cause[9])
        else $error("Extension packet bit not set");

    AST_RESERVED: assert property (
        link.videoFrame |=> s_reg.cause[6] && !s_reg.cause[5])
        else $error("Video bit wrong or reserved bit set");

    AST_TRAIN_LOST: assert property (
        (s_reg.train == sal_pkg::TRN_TRAINED) && !link.linkLocked
        |=> s_reg.cause[4] ##1 !$rose(s_reg.cause[4]) || link.trainDone)
        else $error("Lock loss after training not flagged");

    AST_NO_LOST_UNTRAINED: assert property (
        (s_reg.train == sal_pkg::TRN_IDLE) && !s_reg.cause[4] && !causeHit
        |=> !s_reg.cause[4])
        else $error("Lock loss flagged before training");

    AST_VBLANK: assert property (
        link.bidValid && link.blanking_id_byte[0] && !s_reg.vblPrev |=> s_reg.cause[3])
        else $error("Vertical blanking start not flagged");

    AST_NO_VIDEO: assert property (
        link.bidValid && !link.blanking_id_byte[3]
        ##1 link.bidValid && link.blanking_id_byte[3] |=> s_reg.cause[2])
        else $error("No-video after video not flagged");

    AST_MODE_CHG: assert property (
        s_reg.attrKnown && link.attrValid && (link.stream_attributes != s_reg.attr)
        |=> s_reg.cause[1])
        else $error("Mode change not flagged");

    AST_MASK_RESET: assert property (
        $past(rst) && !rst |-> s_reg.mask == 32'hFFFF_FFFF && !irq)
        else $error("Mask not all ones after reset");

    AST_IRQ_FOLLOWS: assert property (
        irq && bus.rdStb && (bus.addr == 12'h040) && (evSet == 32'h0000_0000)
        && !(bus.wrStb && (bus.addr == 12'h060))
        |=> !irq ##1 (irq == |(s_reg.cause & ~s_reg.mask)))
        else $error("Interrupt did not follow unmasked causes");

    AST_LEN_HOLD: assert property (
        !link.auxReqValid |=> $stable(s_reg.reqLen))
        else $error("Length changed without a request");

    AST_LEN_ZERO_BYTES: assert property (
        link.auxReqValid && (link.auxReqBytes == 5'h00) |=> s_reg.reqLen == 4'h0)
        else $error("Zero-byte request length not zero");

    AST_LEN_READ: assert property (
        bus.rdStb && (bus.addr == 12'h03C)
        |=> rdData == {28'h000_0000, $past(s_reg.reqLen)})
        else $error("Length read returned wrong value");

    AST_RDDATA_IDLE: assert property (
        !bus.rdStb |=> rdData == 32'h0000_0000)
        else $error("Read data not zero outside a read");

    AST_UNUSED_ZERO: assert property (
        (s_reg.cause & ~32'h0007_5E5E) == 32'h0000_0000)
        else $error("Reserved cause bit set");

    AST_MASK_QUIET: assert property (
        bus.wrStb && (bus.addr == 12'h060) && (bus.wrData == 32'hFFFF_FFFF)
        |=> !irq)
        else $error("Interrupt with every source masked");

    AST_UNMASK_RAISES: assert property (
        bus.wrStb && (bus.addr == 12'h060) && (bus.wrData == 32'h0000_0000)
        && (s_reg.cause != 32'h0000_0000)
        |=> irq)
        else $error("Pending cause not raising interrupt once unmasked");

    AST_MASK_READ: assert property (
        bus.rdStb && (bus.addr == 12'h060) |=> rdData == $past(s_reg.mask))
        else $error("Mask read returned wrong value");

    AST_CLEAR_REG: assert property (
        bus.wrStb && (bus.addr == 12'h064) && (evSet == 32'h0000_0000)
        |=> s_reg.cause == ($past(s_reg.cause) & ~$past(bus.wrData)))
        else $error("Clear register did not clear the chosen bits");

    AST_TP_QUIET: assert property (
        !link.tp1Start && !link.tp2Start && !link.tp3Start && (s_reg.cause[18:16] == 3'h0)
        |=> s_reg.cause[18:16] == 3'h0)
        else $error("Training pattern bit set without a start");

    AST_DONE_QUIET: assert property (
        !link.trainDone && !s_reg.cause[14] |=> !s_reg.cause[14])
        else $error("Training complete set without completion");

    AST_DOWN_QUIET: assert property (
        !link.downReqAvail && !s_reg.cause[12] |=> !s_reg.cause[12])
        else $error("Down request bit set without a message");

    AST_VC_QUIET: assert property (
        !link.vcDealloc && !link.vcAlloc && !s_reg.cause[11] && !s_reg.cause[10]
        |=> !s_reg.cause[11] && !s_reg.cause[10])
        else $error("Payload bit set without an event");

    AST_EXT_QUIET: assert property (
        !link.extension_packet_arrived && !s_reg.cause[9] |=> !s_reg.cause[9])
        else $error("Extension packet bit set without a packet");

    AST_VIDEO_QUIET: assert property (
        !link.videoFrame && !s_reg.cause[6] |=> !s_reg.cause[6])
        else $error("Video bit set without a frame");

    AST_LOST_NEEDS_LOSS: assert property (
        link.linkLocked && !s_reg.cause[4] |=> !s_reg.cause[4])
        else $error("Lock loss flagged while locked");

    AST_VBLANK_ONLY_BID: assert property (
        !link.bidValid && !s_reg.cause[3] |=> !s_reg.cause[3])
        else $error("Vertical blanking set without a blanking byte");

    AST_NO_VIDEO_ONLY_BID: assert property (
        !link.bidValid && !s_reg.cause[2] |=> !s_reg.cause[2])
        else $error("No-video set without a blanking byte");

    AST_MODE_ONLY_ATTR: assert property (
        !link.attrValid && !s_reg.cause[1] |=> !s_reg.cause[1])
        else $error("Mode change set without attributes");

    AST_MODE_FIRST: assert property (
        !s_reg.attrKnown && !s_reg.cause[1] |=> !s_reg.cause[1])
        else $error("Mode change flagged on first attributes");

    // Every cause bit holds while neither strobe is active; catches a bit that drops with no bus access at all
    for (genvar g = 0; g < 32; g++)
    begin : gen_sticky
        AST_CAUSE_STICKY: assert property (
            s_reg.cause[g] && !bus.rdStb && !bus.wrStb |=> s_reg.cause[g])
            else $error("Cause bit dropped without an access");
    end

endmodule
`default_nettype wire

// File: sal_link_src.sv
`timescale 1ns/1ps
`default_nettype none

module sal_link_src
(
    input  wire logic                  mclk,
    output var  sal_pkg::sal_link_ev_t link
);
    sal_pkg::sal_link_ev_t ev    = '0;
    logic                  lock  = 1'b1;
    logic [47:0]           noise = 48'hA5C3_1E96_7B24;

    // Attribute, blanking id and byte-count fields carry a pattern that changes each cycle while unqualified, so a design that samples them off-strobe is caught
    always_comb
    begin
        link = ev;
        link.linkLocked = lock;
        if (!ev.attrValid)
            link.stream_attributes = noise;
        if (!ev.bidValid)
            link.blanking_id_byte = noise[7:0];
        if (!ev.auxReqValid)
            link.auxReqBytes = noise[12:8];
    end

    always @(posedge mclk)
        noise <= ~{noise[46:0], noise[47]};

    task automatic pulse(input sal_pkg::sal_link_ev_t e);
        @(posedge mclk);
        ev <= e;
        @(posedge mclk);
        ev <= '0;
    endtask

    // Second edge lets the design sample the new level before the caller acts
    task automatic set_lock(input logic v);
        @(posedge mclk);
        lock <= v;
        @(posedge mclk);
    endtask
endmodule

`default_nettype wire

// File: tb.sv
`include "sal_aux_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                  mclk = 1'b0;
    logic                  rst  = 1'b1;
    sal_pkg::sal_bus_req_t bus  = '0;
    sal_pkg::sal_link_ev_t link;
    sal_pkg::sal_link_ev_t e;
    logic [31:0]           rdData;
    logic                  irq;
    logic [31:0]           m;
    logic [31:0]           x;
    logic [8:0]            s;
    int                    miscompares = 0;
    int                    cmpCount = 0;
    // Strobe positions inside the link struct and the cause bits they raise
    int                    evPos[9] = '{74, 73, 72, 71, 69, 68, 67, 66, 65};
    int                    cbPos[9] = '{16, 17, 18, 14, 12, 11, 10, 9, 6};

    sal_aux_irq i_dut
    (
        .mclk   (mclk),
        .rst    (rst),
        .bus    (bus),
        .link   (link),
        .rdData (rdData),
        .irq    (irq)
    );

    sal_link_src i_src
    (
        .mclk (mclk),
        .link (link)
    );

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    task automatic close_out;
        $display("comparisons %0d miscompares %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
        @(posedge mclk);
        bus.wrStb <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wrData: 32'h0, wrStb: 1'b0, rdStb: 1'b1};
        @(posedge mclk);
        bus.rdStb <= 1'b0;
        #1 check(rdData, exp);
    endtask

    task automatic fire(input logic [8:0] sel);
        e = '0;
        for (int k = 0; k < 9; k++)
            if (sel[k])
                e[evPos[k]] = 1'b1;
        i_src.pulse(e);
    endtask

    task automatic bid(input logic [7:0] b, input logic [31:0] exp);
        e = '0;
        e.bidValid = 1'b1;
        e.blanking_id_byte = b;
        i_src.pulse(e);
        rd(`SAL_OFS_CAUSE, exp);
    endtask

    task automatic attr(input logic [47:0] v, input logic [31:0] exp);
        e = '0;
        e.attrValid = 1'b1;
        e.stream_attributes = v;
        i_src.pulse(e);
        rd(`SAL_OFS_CAUSE, exp);
    endtask

    task automatic aux(input logic [4:0] n, input logic ao, input logic [31:0] exp);
        e = '0;
        e.auxReqValid = 1'b1;
        e.auxAddrOnly = ao;
        e.auxReqBytes = n;
        i_src.pulse(e);
        rd(`SAL_OFS_REQ_LEN, exp);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'h1b74));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(`SAL_OFS_REQ_LEN, 32'h0);
        rd(`SAL_OFS_MASK, 32'hFFFF_FFFF);
        wr(12'h100, 32'hFFFF_FFFF);
        rd(12'h100, 32'h0);
        attr(48'h0123_4567_89AB, 32'h0);
        attr(48'h0123_4567_89AB, 32'h0);
        attr(48'h0123_4567_89AC, 32'h0000_0002);
        fire(9'h100);
        #1 check({31'h0, irq}, 32'h0);
        rd(`SAL_OFS_CAUSE, 32'h0000_0040);
        for (int i = 0; i < 24; i++)
        begin
            m = $urandom;
            s = (i == 0) ? 9'h1FF : 9'($urandom);
            x = '0;
            for (int k = 0; k < 9; k++)
                if (s[k])
                    x[cbPos[k]] = 1'b1;
            wr(`SAL_OFS_MASK, m);
            fire(s);
            #1 check({31'h0, irq}, {31'h0, |(x & ~m)});
            rd(`SAL_OFS_CAUSE, x);
            check({31'h0, irq}, 32'h0);
            rd(`SAL_OFS_CAUSE, 32'h0);
        end
        fire(9'h008);
        rd(`SAL_OFS_CAUSE, 32'h0000_4000);
        i_src.set_lock(1'b0);
        rd(`SAL_OFS_CAUSE, 32'h0000_0010);
        i_src.set_lock(1'b1);
        fire(9'h001);
        rd(`SAL_OFS_CAUSE, 32'h0001_0000);
        i_src.set_lock(1'b0);
        rd(`SAL_OFS_CAUSE, 32'h0);
        i_src.set_lock(1'b1);
        bid(8'h00, 32'h0);
        bid(8'h01, 32'h0000_0008);
        bid(8'h01, 32'h0);
        bid(8'h08, 32'h0000_0004);
        for (int b = 1; b <= 16; b++)
            aux(5'(b), 1'b0, 32'(b - 1));
        aux(5'h11, 1'b0, 32'hF);
        aux(5'h05, 1'b1, 32'h0);
        aux(5'h09, 1'b0, 32'h8);
        aux(5'h00, 1'b0, 32'h0);
        fire(9'h060);
        wr(`SAL_OFS_CAUSE_CLR, 32'h0000_0400);
        rd(`SAL_OFS_CAUSE, 32'h0000_0800);
        fire(9'h080);
        wr(`SAL_OFS_CAUSE, $urandom);
        rd(`SAL_OFS_CAUSE, 32'h0);
        wr(`SAL_OFS_MASK, 32'h0);
        fire(9'h002);
        #1 check({31'h0, irq}, 32'h1);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        rd(`SAL_OFS_MASK, 32'hFFFF_FFFF);
        check({31'h0, irq}, 32'h0);
        rd(`SAL_OFS_CAUSE, 32'h0);
        close_out();
    end
endmodule

`default_nettype wire
